// [hdl/acig_pkg.sv]
package acig_pkg;
    // ------------------------------------------------------------
    // parameter request coding
    // ------------------------------------------------------------
    localparam logic [7:0]  REQ_LEN       = 8'h02;
    localparam logic [7:0]  IDX_HI        = 8'h24;
    localparam logic [7:0]  IDX_OFS_LO    = 8'h00;
    localparam logic [7:0]  IDX_MAX_LO    = 8'h01;
    localparam logic [7:0]  IDX_AVG_LO    = 8'h02;
    localparam logic [7:0]  SUB_CH1       = 8'h01;
    localparam logic [7:0]  SUB_CH2       = 8'h02;
    localparam logic [7:0]  SUB_MODULE    = 8'h00;
    // ------------------------------------------------------------
    // value ranges and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] OFS_MIN       = 16'he001;
    localparam logic [15:0] OFS_MAX       = 16'h1fff;
    localparam logic [15:0] MAX_MIN       = 16'h5cf8;
    localparam logic [15:0] MAX_MAX       = 16'h7fff;
    localparam logic [15:0] FULL_SCALE    = 16'h7d00;
    localparam logic [15:0] OFS_RST       = 16'h0000;
    localparam logic [15:0] MAX_RST       = 16'h7d00;
    localparam logic [7:0]  AVG_MIN       = 8'h01;
    localparam logic [7:0]  AVG_MAX       = 8'h08;
    localparam logic [7:0]  AVG_RST       = 8'h01;
    localparam int unsigned AVG_DEPTH     = 8;
    // ------------------------------------------------------------
    // input image
    // ------------------------------------------------------------
    localparam logic [15:0] IMG_AREA_BASE = 16'hb150;
    localparam logic [15:0] IMG_AREA_LAST = 16'hc14f;
    localparam logic [9:0]  IMG_SLOT_MAX  = 10'h3ff;
    localparam logic [1:0]  IMG_CH1_DATA  = 2'h0;
    localparam logic [1:0]  IMG_CH1_STAT  = 2'h1;
    localparam logic [1:0]  IMG_CH2_DATA  = 2'h2;
    localparam logic [1:0]  IMG_CH2_STAT  = 2'h3;
    localparam int unsigned FIFO_DEPTH    = 16;
    localparam logic [15:0] GIE_INDEX     = 16'h1917;
    localparam logic [7:0]  GIE_SUB       = 8'h01;
    // ------------------------------------------------------------
    // controller registers (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  A_CTRL        = 8'h00;
    localparam logic [7:0]  A_REQ         = 8'h04;
    localparam logic [7:0]  A_DATA        = 8'h08;
    localparam logic [7:0]  A_STAT        = 8'h0c;
    localparam logic [7:0]  A_SLOT        = 8'h10;
    localparam logic [7:0]  A_IMG0        = 8'h20;
    localparam logic [7:0]  A_IMG1        = 8'h24;
    localparam logic [7:0]  A_IMG2        = 8'h28;
    localparam logic [7:0]  A_IMG3        = 8'h2c;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    typedef enum logic {ACIG_DS_IDLE = 1'b0, ACIG_DS_PUSH = 1'b1} acig_dev_st_t;
    typedef enum logic [1:0] {ACIG_HS_IDLE = 2'b00, ACIG_HS_SEND = 2'b01, ACIG_HS_WAIT = 2'b10} acig_nim_st_t;
endpackage

// [hdl/acig_if.sv]
interface acig_if;
    logic        req_valid;
    logic        req_ready;
    logic        req_write;
    logic [7:0]  req_len;
    logic [7:0]  req_idx_lo;
    logic [7:0]  req_idx_hi;
    logic [7:0]  req_sub;
    logic [7:0]  req_byte1;
    logic [7:0]  req_byte2;
    logic        rsp_valid;
    logic        rsp_err;
    logic [15:0] rsp_data;
    logic        cfg_commit;
    logic        img_valid;
    logic        img_ready;
    logic [1:0]  img_sel;
    logic [15:0] img_word;

    modport dev (input req_valid, req_write, req_len, req_idx_lo, req_idx_hi, req_sub, req_byte1, req_byte2,
                 input cfg_commit, img_ready,
                 output req_ready, rsp_valid, rsp_err, rsp_data, img_valid, img_sel, img_word);
    modport nim (output req_valid, req_write, req_len, req_idx_lo, req_idx_hi, req_sub, req_byte1, req_byte2,
                 output cfg_commit, img_ready,
                 input req_ready, rsp_valid, rsp_err, rsp_data, img_valid, img_sel, img_word);
endinterface

// [hdl/acig_fifo.sv]
module acig_fifo #(
    parameter int unsigned WIDTH = 18,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } acig_fifo_st_t;

    acig_fifo_st_t r_reg, r_next;
    logic          push;
    logic          pop;

    assign in_ready  = (r_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid = (r_reg.cnt != '0);
    assign out_data  = r_reg.mem[r_reg.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        r_next = r_reg;
        if (push) begin
            r_next.mem[r_reg.wr] = in_data;
            r_next.wr            = (r_reg.wr == AW'(DEPTH-1)) ? '0 : r_reg.wr + 1'b1;
        end
        if (pop) begin
            r_next.rd = (r_reg.rd == AW'(DEPTH-1)) ? '0 : r_reg.rd + 1'b1;
        end
        if (push && !pop) begin
            r_next.cnt = r_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            r_next.cnt = r_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule

// [hdl/acig_dev.sv]
module acig_dev #(
    parameter int unsigned FIFO_DEPTH = acig_pkg::FIFO_DEPTH
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    acig_if.dev                     link,
    input  wire logic               sample_valid,
    output logic                    sample_ready,
    input  wire logic signed [15:0] ch1_raw,
    input  wire logic signed [15:0] ch2_raw,
    input  wire logic [15:0]        ch1_status,
    input  wire logic [15:0]        ch2_status,
    output logic [7:0]              avg_active
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0][15:0]      ofs_pend;
        logic [1:0][15:0]      max_pend;
        logic [7:0]            avg_pend;
        logic [1:0][15:0]      ofs_act;
        logic [1:0][15:0]      max_act;
        logic [7:0]            avg_act;
        logic [1:0][7:0][15:0] hist;
        logic [3:0][15:0]      words;
        logic [1:0]            sel;
        acig_pkg::acig_dev_st_t st;
        logic                  rsp_valid;
        logic                  rsp_err;
        logic [15:0]           rsp_data;
    } acig_dev_state_t;

    acig_dev_state_t r_reg, r_next;
    logic            fifo_in_valid;
    logic            fifo_in_ready;
    logic [17:0]     fifo_out;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [15:0] acig_calib(input logic [15:0] raw, input logic [15:0] ofs,
                                               input logic [15:0] mx);
        logic signed [16:0] d;
        logic signed [32:0] prod;
        logic signed [32:0] q;
        d    = $signed({raw[15], raw}) - $signed({ofs[15], ofs});
        prod = $signed({{16{d[16]}}, d}) * $signed({17'h00000, acig_pkg::FULL_SCALE});
        q    = prod / $signed({17'h00000, mx});
        if (q < 0) begin
            return 16'h0000;
        end else if (q > $signed({17'h00000, acig_pkg::MAX_MAX})) begin
            return acig_pkg::MAX_MAX;
        end
        return q[15:0];
    endfunction

    function automatic logic [15:0] acig_mean(input logic [7:0][15:0] h, input logic [7:0] n);
        logic [18:0] s;
        s = 19'h00000;
        for (int i = 0; i < acig_pkg::AVG_DEPTH; i++) begin
            if (8'(i) < n) begin
                s = s + {3'h0, h[i]};
            end
        end
        return 16'(s / {11'h000, n});
    endfunction

    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        return ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0]           val;
        logic                  ch;
        logic [1:0][15:0]      cal;
        logic [1:0][7:0][15:0] h;
        val    = {link.req_byte2, link.req_byte1};
        ch     = (link.req_sub == acig_pkg::SUB_CH2);
        cal    = '0;
        h      = r_reg.hist;
        r_next = r_reg;
        r_next.rsp_valid = 1'b0;

        if (link.req_valid && link.req_ready) begin
            r_next.rsp_valid = 1'b1;
            r_next.rsp_err   = 1'b1;
            r_next.rsp_data  = 16'h0000;
            if (link.req_len == acig_pkg::REQ_LEN && link.req_idx_hi == acig_pkg::IDX_HI) begin
                if (link.req_idx_lo == acig_pkg::IDX_OFS_LO &&
                    (link.req_sub == acig_pkg::SUB_CH1 || link.req_sub == acig_pkg::SUB_CH2)) begin
                    if (!link.req_write) begin
                        r_next.rsp_err  = 1'b0;
                        r_next.rsp_data = r_reg.ofs_pend[ch];
                    end else if (in_range(val, acig_pkg::OFS_MIN, acig_pkg::OFS_MAX)) begin
                        r_next.rsp_err      = 1'b0;
                        r_next.ofs_pend[ch] = val;
                    end
                end else if (link.req_idx_lo == acig_pkg::IDX_MAX_LO &&
                             (link.req_sub == acig_pkg::SUB_CH1 || link.req_sub == acig_pkg::SUB_CH2)) begin
                    if (!link.req_write) begin
                        r_next.rsp_err  = 1'b0;
                        r_next.rsp_data = r_reg.max_pend[ch];
                    end else if (in_range(val, acig_pkg::MAX_MIN, acig_pkg::MAX_MAX)) begin
                        r_next.rsp_err      = 1'b0;
                        r_next.max_pend[ch] = val;
                    end
                end else if (link.req_idx_lo == acig_pkg::IDX_AVG_LO &&
                             link.req_sub == acig_pkg::SUB_MODULE) begin
                    if (!link.req_write) begin
                        r_next.rsp_err  = 1'b0;
                        r_next.rsp_data = {8'h00, r_reg.avg_pend};
                    end else if (link.req_byte1 >= acig_pkg::AVG_MIN &&
                                 link.req_byte1 <= acig_pkg::AVG_MAX) begin
                        r_next.rsp_err  = 1'b0;
                        r_next.avg_pend = link.req_byte1;
                    end
                end
            end
        end

        if (link.cfg_commit) begin
            r_next.ofs_act = r_next.ofs_pend;
            r_next.max_act = r_next.max_pend;
            r_next.avg_act = r_next.avg_pend;
        end

        unique case (r_reg.st)
            acig_pkg::ACIG_DS_IDLE: begin
                if (sample_valid) begin
                    cal[0] = acig_calib(ch1_raw, r_reg.ofs_act[0], r_reg.max_act[0]);
                    cal[1] = acig_calib(ch2_raw, r_reg.ofs_act[1], r_reg.max_act[1]);
                    for (int c = 0; c < 2; c++) begin
                        h[c] = {r_reg.hist[c][6:0], cal[c]};
                    end
                    r_next.hist = h;
                    r_next.words[acig_pkg::IMG_CH1_DATA] = acig_mean(h[0], r_reg.avg_act);
                    r_next.words[acig_pkg::IMG_CH1_STAT] = ch1_status;
                    r_next.words[acig_pkg::IMG_CH2_DATA] = acig_mean(h[1], r_reg.avg_act);
                    r_next.words[acig_pkg::IMG_CH2_STAT] = ch2_status;
                    r_next.sel = 2'h0;
                    r_next.st  = acig_pkg::ACIG_DS_PUSH;
                end
            end
            acig_pkg::ACIG_DS_PUSH: begin
                if (fifo_in_ready) begin
                    r_next.sel = r_reg.sel + 2'h1;
                    if (r_reg.sel == acig_pkg::IMG_CH2_STAT) begin
                        r_next.st = acig_pkg::ACIG_DS_IDLE;
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg          <= '0;
            r_reg.ofs_pend <= {2{acig_pkg::OFS_RST}};
            r_reg.max_pend <= {2{acig_pkg::MAX_RST}};
            r_reg.ofs_act  <= {2{acig_pkg::OFS_RST}};
            r_reg.max_act  <= {2{acig_pkg::MAX_RST}};
            r_reg.avg_pend <= acig_pkg::AVG_RST;
            r_reg.avg_act  <= acig_pkg::AVG_RST;
            r_reg.st       <= acig_pkg::ACIG_DS_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // image words out through the fifo
    // ------------------------------------------------------------
    assign fifo_in_valid  = (r_reg.st == acig_pkg::ACIG_DS_PUSH);
    assign sample_ready   = (r_reg.st == acig_pkg::ACIG_DS_IDLE);
    assign link.req_ready = !r_reg.rsp_valid;
    assign link.rsp_valid = r_reg.rsp_valid;
    assign link.rsp_err   = r_reg.rsp_err;
    assign link.rsp_data  = r_reg.rsp_data;
    assign link.img_sel   = fifo_out[17:16];
    assign link.img_word  = fifo_out[15:0];
    assign avg_active     = r_reg.avg_act;

    acig_fifo #(
        .WIDTH (18),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({r_reg.sel, r_reg.words[r_reg.sel]}),
        .out_valid (link.img_valid),
        .out_ready (link.img_ready),
        .out_data  (fifo_out)
    );
endmodule

// [hdl/acig_nim.sv]
module acig_nim (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    acig_if.nim              link,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                   wr_pend;
        logic [7:0]             wr_addr;
        logic [31:0]            rdata;
        logic                   gie;
        logic                   req_write;
        logic [31:0]            req;
        logic [15:0]            data;
        logic                   done;
        logic                   err;
        logic [15:0]            rsp_data;
        logic [9:0]             slot;
        logic [3:0][15:0]       img;
        logic                   commit;
        acig_pkg::acig_nim_st_t st;
    } acig_nim_state_t;

    acig_nim_state_t r_reg, r_next;
    logic [15:0]     img_base;

    assign img_base = acig_pkg::IMG_AREA_BASE + {4'h0, r_reg.slot, 2'h0};

    always_comb begin
        logic [7:0] a;
        a      = haddr[7:0];
        r_next = r_reg;
        r_next.commit  = 1'b0;
        r_next.wr_pend = hsel && hready && htrans == acig_pkg::HTRANS_NONSEQ && hwrite;
        r_next.wr_addr = a;
        if (hsel && hready && htrans == acig_pkg::HTRANS_NONSEQ && !hwrite) begin
            unique case (a)
                acig_pkg::A_CTRL: r_next.rdata = {28'h0000000, 1'b0, r_reg.req_write, 1'b0, r_reg.gie};
                acig_pkg::A_REQ:  r_next.rdata = r_reg.req;
                acig_pkg::A_DATA: r_next.rdata = {16'h0000, r_reg.data};
                acig_pkg::A_STAT: r_next.rdata = {r_reg.rsp_data, 13'h0000, r_reg.err, r_reg.done,
                                                  r_reg.st != acig_pkg::ACIG_HS_IDLE};
                acig_pkg::A_SLOT: r_next.rdata = {img_base, 6'h00, r_reg.slot};
                acig_pkg::A_IMG0: r_next.rdata = {16'h0000, r_reg.img[0]};
                acig_pkg::A_IMG1: r_next.rdata = {16'h0000, r_reg.img[1]};
                acig_pkg::A_IMG2: r_next.rdata = {16'h0000, r_reg.img[2]};
                acig_pkg::A_IMG3: r_next.rdata = {16'h0000, r_reg.img[3]};
                default:          r_next.rdata = 32'h00000000;
            endcase
        end
        if (r_reg.wr_pend) begin
            unique case (r_reg.wr_addr)
                acig_pkg::A_CTRL: begin
                    r_next.gie       = hwdata[0];
                    r_next.req_write = hwdata[2];
                    r_next.commit    = hwdata[3];
                    if (hwdata[1] && r_reg.st == acig_pkg::ACIG_HS_IDLE) begin
                        r_next.st   = acig_pkg::ACIG_HS_SEND;
                        r_next.done = 1'b0;
                    end
                end
                acig_pkg::A_REQ:  r_next.req  = hwdata;
                acig_pkg::A_DATA: r_next.data = hwdata[15:0];
                acig_pkg::A_SLOT: r_next.slot = hwdata[9:0];
                default: ;
            endcase
        end
        unique case (r_reg.st)
            acig_pkg::ACIG_HS_IDLE: ;
            acig_pkg::ACIG_HS_SEND: begin
                if (link.req_ready) begin
                    r_next.st = acig_pkg::ACIG_HS_WAIT;
                end
            end
            acig_pkg::ACIG_HS_WAIT: begin
                if (link.rsp_valid) begin
                    r_next.done     = 1'b1;
                    r_next.err      = link.rsp_err;
                    r_next.rsp_data = link.rsp_data;
                    r_next.st       = acig_pkg::ACIG_HS_IDLE;
                end
            end
            default: r_next.st = acig_pkg::ACIG_HS_IDLE;
        endcase
        if (link.img_valid && link.img_ready) begin
            r_next.img[link.img_sel] = link.img_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg    <= '0;
            r_reg.st <= acig_pkg::ACIG_HS_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // link and bus outputs
    // ------------------------------------------------------------
    assign link.req_valid  = (r_reg.st == acig_pkg::ACIG_HS_SEND);
    assign link.req_write  = r_reg.req_write;
    assign link.req_idx_lo = r_reg.req[7:0];
    assign link.req_idx_hi = r_reg.req[15:8];
    assign link.req_sub    = r_reg.req[23:16];
    assign link.req_len    = r_reg.req[31:24];
    assign link.req_byte1  = r_reg.data[7:0];
    assign link.req_byte2  = r_reg.data[15:8];
    assign link.cfg_commit = r_reg.commit;
    assign link.img_ready  = r_reg.gie;
    assign hrdata          = r_reg.rdata;
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
endmodule

// [tb/acig_properties.sv]
module acig_properties (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       req_valid,
    input wire logic       req_ready,
    input wire logic       req_write,
    input wire logic [7:0] req_len,
    input wire logic [7:0] req_idx_lo,
    input wire logic [7:0] req_idx_hi,
    input wire logic [7:0] req_sub,
    input wire logic [7:0] req_byte1,
    input wire logic [7:0] req_byte2,
    input wire logic       rsp_valid,
    input wire logic       rsp_err,
    input wire logic       img_valid,
    input wire logic       img_ready,
    input wire logic [1:0] img_sel
);
    // ------------------------------------------------------------
    // link and image checks
    // ------------------------------------------------------------
    logic               take;
    logic               wr_ok;
    logic               max_bad;
    logic               ofs_bad;
    logic               avg_bad;
    logic signed [15:0] val;
    assign take    = req_valid && req_ready;
    assign wr_ok   = take && req_write && req_len == 8'h02 && req_idx_hi == 8'h24;
    assign val     = {req_byte2, req_byte1};
    assign max_bad = val < 16'sd23800;
    assign ofs_bad = val < -16'sd8191 || val > 16'sd8191;
    assign avg_bad = req_byte1 < 8'h01 || req_byte1 > 8'h08;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_rsp_next_cycle: assert property (take |=> rsp_valid)
        else $error("request not answered in the next cycle");
    a_rsp_one_pulse: assert property (rsp_valid |-> !req_ready ##1 !rsp_valid)
        else $error("response longer than one cycle");
    a_len_refused: assert property (take && req_len != 8'h02 |=> rsp_err)
        else $error("wrong length not refused");
    a_index_refused: assert property (take && req_idx_hi != 8'h24 |=> rsp_err)
        else $error("wrong index high byte not refused");
    a_max_range: assert property (wr_ok && req_idx_lo == 8'h01 && req_sub inside {8'h01, 8'h02}
        |=> rsp_err == $past(max_bad)) else $error("maximum count range wrong");
    a_ofs_range: assert property (wr_ok && req_idx_lo == 8'h00 && req_sub inside {8'h01, 8'h02}
        |=> rsp_err == $past(ofs_bad)) else $error("offset range wrong");
    a_avg_range: assert property (wr_ok && req_idx_lo == 8'h02 && req_sub == 8'h00
        |=> rsp_err == $past(avg_bad)) else $error("averaging range wrong");
    a_image_order: assert property (img_valid && img_ready ##1 img_valid |-> img_sel == $past(img_sel) + 2'h1)
        else $error("image words out of order");
endmodule

// [tb/acig_tb.sv]
module acig_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // bench signals and model state
    // ------------------------------------------------------------
`define CHK(n, e, g) begin tests_run++; if (32'(g) !== 32'(e)) begin error_cnt++; \
    $display("MISMATCH %s expected %0h seen %0h", n, 32'(e), 32'(g)); end end
`define WAIT(c) begin @(negedge hclk); for (int n_ = 0; !(c); n_++) begin if (n_ > 300) timeout(); \
    @(negedge hclk); end end
    logic               hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, sample_valid = 1'b0, gie = 1'b0;
    logic               hreadyout, hresp, sample_ready;
    logic [31:0]        haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]         htrans = 2'h0;
    logic [2:0]         hsize = 3'h2;
    logic signed [15:0] ch1_raw = 16'h0, ch2_raw = 16'h0;
    logic [15:0]        ch1_status = 16'h0, ch2_status = 16'h0;
    logic [7:0]         avg_active;
    int error_cnt = 0, tests_run = 0, seed = 32'h4cf047fd, avg = 1, pavg = 1, slot, img[4], hist[2][$];
    int ofs[2] = '{0, 0}, pofs[2] = '{0, 0}, mx[2] = '{32000, 32000}, pmx[2] = '{32000, 32000};
    int tl[12] = '{1, 1, 1, 1, 0, 0, 0, 0, 2, 2, 2, 2};
    int tv[12] = '{23799, 32768, 23800, 31744, -8192, 8192, 8191, 64, 0, 9, 8, 4};
    always #2 hclk = ~hclk;
    acig_if link ();
    acig_dev acig_dev_i (.hclk, .hresetn, .link(link.dev), .sample_valid, .sample_ready, .ch1_raw, .ch2_raw,
        .ch1_status, .ch2_status, .avg_active);
    acig_nim acig_nim_i (.hclk, .hresetn, .link(link.nim), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp);
    acig_properties acig_properties_i (.hclk, .hresetn, .req_valid(link.req_valid), .req_ready(link.req_ready),
        .req_write(link.req_write), .req_len(link.req_len), .req_idx_lo(link.req_idx_lo),
        .req_idx_hi(link.req_idx_hi), .req_sub(link.req_sub), .req_byte1(link.req_byte1),
        .req_byte2(link.req_byte2), .rsp_valid(link.rsp_valid), .rsp_err(link.rsp_err),
        .img_valid(link.img_valid), .img_ready(link.img_ready), .img_sel(link.img_sel));
    task automatic tally_and_finish();
        if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic timeout();
        error_cnt++;
        tally_and_finish();
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= acig_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        `WAIT(hreadyout)
        @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        `WAIT(hreadyout)
        @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic runtime_parameter_access(input logic w, input int hi, lo, sub, len, v);
        int e, d;
        e = len != 2 || hi != 8'h24 || lo > 2 || (lo == 2 ? sub != 0 : sub < 1 || sub > 2);
        if (!e && w) e = lo == 0 ? v < -8191 || v > 8191 : lo == 1 ? v < 23800 || v > 32767 : v < 1 || v > 8;
        ahb(1'b1, acig_pkg::A_DATA, {16'h0, v[15:0]});
        ahb(1'b1, acig_pkg::A_REQ, {len[7:0], sub[7:0], hi[7:0], lo[7:0]});
        ahb(1'b1, acig_pkg::A_CTRL, {28'h0, 1'b0, w, 1'b1, gie});
        rd = 32'h0;
        for (int n = 0; n < 40 && !rd[1]; n++) ahb(1'b0, acig_pkg::A_STAT, 32'h0);
        if (!rd[1]) timeout();
        `CHK("rsp_err", e, rd[2])
        d = lo == 0 ? pofs[sub - 1] : lo == 1 ? pmx[sub - 1] : pavg;
        if (!e && !w) `CHK("rsp_data", d[15:0], rd[31:16])
        if (!e && w && lo == 0) pofs[sub - 1] = v;
        if (!e && w && lo == 1) pmx[sub - 1] = v;
        if (!e && w && lo == 2) pavg = v;
    endtask
    task automatic push(input int r1, r2);
        int c, s;
        @(posedge hclk);
        sample_valid <= 1'b1;
        ch1_raw <= 16'(r1);
        ch2_raw <= 16'(r2);
        ch1_status <= 16'($random(seed));
        ch2_status <= 16'($random(seed));
        `WAIT(sample_ready)
        @(posedge hclk);
        sample_valid <= 1'b0;
        for (int ch = 0; ch < 2; ch++) begin
            c = ((ch ? r2 : r1) - ofs[ch]) * 32000 / mx[ch];
            hist[ch].push_front(c < 0 ? 0 : c > 32767 ? 32767 : c);
            s = 0;
            for (int i = 0; i < avg && i < hist[ch].size(); i++) s += hist[ch][i];
            img[2 * ch] = s / avg;
            img[2 * ch + 1] = ch ? ch2_status : ch1_status;
        end
    endtask
    task automatic check_img();
        `WAIT(!link.img_valid && sample_ready)
        for (int i = 0; i < 4; i++) begin
            ahb(1'b0, acig_pkg::A_IMG0 + 8'(4 * i), 32'h0);
            `CHK("image word", img[i][15:0], rd[15:0])
        end
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        for (int s = 1; s < 3; s++) runtime_parameter_access(1'b0, 36, 0, s, 2, 0);
        for (int s = 1; s < 3; s++) runtime_parameter_access(1'b0, 36, 1, s, 2, 0);
        runtime_parameter_access(1'b0, 36, 2, 0, 2, 0);
        runtime_parameter_access(1'b1, 36, 1, 1, 3, 30000);
        runtime_parameter_access(1'b1, 37, 1, 1, 2, 30000);
        runtime_parameter_access(1'b1, 36, 1, 3, 2, 30000);
        runtime_parameter_access(1'b1, 36, 3, 0, 2, 1);
        runtime_parameter_access(1'b1, 36, 2, 1, 2, 4);
        for (int i = 0; i < 12; i++) begin
            runtime_parameter_access(1'b1, 36, tl[i], tl[i] == 2 ? 0 : 1 + i % 2, 2, tv[i]);
            runtime_parameter_access(1'b0, 36, tl[i], tl[i] == 2 ? 0 : 1 + i % 2, 2, 0);
        end
        `CHK("avg_active", 8'h01, avg_active)
        ahb(1'b1, acig_pkg::A_CTRL, {28'h0, 1'b1, 2'h0, gie});
        ofs = pofs;
        mx = pmx;
        avg = pavg;
        `WAIT(avg_active == 8'h04)
        `CHK("avg_active", 8'h04, avg_active)
        gie = 1'b1;
        ahb(1'b1, acig_pkg::A_CTRL, {31'h0, gie});
        push(8191, 31808);
        check_img();
        repeat (12) begin
            push($random(seed) % 32768, $random(seed) % 32768);
            check_img();
        end
        gie = 1'b0;
        ahb(1'b1, acig_pkg::A_CTRL, {31'h0, gie});
        repeat (5) push($random(seed) % 32768, $random(seed) % 32768);
        repeat (8) @(posedge hclk);
        `CHK("sample_ready", 1'b0, sample_ready)
        `CHK("img_valid", 1'b1, link.img_valid)
        gie = 1'b1;
        ahb(1'b1, acig_pkg::A_CTRL, {31'h0, gie});
        check_img();
        slot = $random(seed) & 1023;
        ahb(1'b1, acig_pkg::A_SLOT, 32'(slot));
        ahb(1'b0, acig_pkg::A_SLOT, 32'h0);
        `CHK("image base", 45392 + 4 * slot, rd[31:16])
        `CHK("slot", slot, rd[9:0])
        tally_and_finish();
    end
endmodule
